/* File: inc/otpc_regs.vh */
/*
 Constants for the memory programmer: widths, supply codes and timing.
 Assumes a 125 MHz clock; included by every file of the block.
*/
`ifndef OTPC_REGS_VH
`define OTPC_REGS_VH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define OTPC_ADDR_W        17
`define OTPC_DATA_W        8
`define OTPC_LAST_ADDR     17'h1FFFF
`define OTPC_ID_SEL_BIT    0

// ---------------------------------------------------------------
// Supply level requests (2 bits: 0 off, 1 normal 5.0 V, 2 program)
// ---------------------------------------------------------------
`define OTPC_SUP_OFF       2'h0
`define OTPC_SUP_NORM      2'h1
`define OTPC_SUP_PROG      2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define OTPC_CLK_NS        8
`define OTPC_PULSE_NS      100000
`define OTPC_SETUP_NS      2000
`define OTPC_PULSE_CYC     ((`OTPC_PULSE_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_SETUP_CYC     ((`OTPC_SETUP_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_RETRY_MAX     4'hA
`define OTPC_TMR_W         14

`endif

/* File: src/otpc_timer.v */
/*
 Down-counting delay timer used for setup, strobe and access waits.
 Assumes one clock, asynchronous active-high reset and a clock enable.
*/
`timescale 1ns/100ps
`include "otpc_regs.vh"

module otpc_timer
(
   // Clock and reset
   input  wire                    clk_i,
   input  wire                    rst_i,
   input  wire                    ce_i,
   // Control
   input  wire                    load_i,
   input  wire [`OTPC_TMR_W-1:0]  count_i,
   output wire                    done_o
);

   reg [`OTPC_TMR_W-1:0] remain;

   // Load a count, then tick down to zero
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         remain <= {`OTPC_TMR_W{1'b0}};
      else if (ce_i)
      begin
         if (load_i)
            remain <= count_i;
         else if (remain != {`OTPC_TMR_W{1'b0}})
            remain <= remain - 1'b1;
      end
   end

   assign done_o = (remain == {`OTPC_TMR_W{1'b0}}) && !load_i;

endmodule // otpc_timer

/* File: src/otpc_programmer.v */
/*
 Programmer for a byte-wide one-time-programmable memory: pulse-and-verify
 programming and single or identification reads. Supply and id-voltage
 outputs are level requests to regulators, settled within the setup wait.
*/
`timescale 1ns/100ps
`include "otpc_regs.vh"

module otpc_programmer
(
   // Clock and reset
   input  wire                    clk_i,
   input  wire                    rst_i,
   input  wire                    ce_i,
   // User commands
   input  wire                    prog_start_i,
   input  wire                    read_start_i,
   input  wire                    read_id_i,
   input  wire [`OTPC_ADDR_W-1:0] read_addr_i,
   output wire                    busy_o,
   // Program data source, indexed by data_addr_o
   output reg                     data_req_o,
   output reg  [`OTPC_ADDR_W-1:0] data_addr_o,
   input  wire [`OTPC_DATA_W-1:0] data_i,
   input  wire                    data_valid_i,
   // Results
   output reg  [`OTPC_DATA_W-1:0] read_data_o,
   output reg                     read_done_o,
   output reg                     prog_done_o,
   output reg                     prog_pass_o,
   output reg  [`OTPC_ADDR_W-1:0] fail_addr_o,
   // Device pins
   output reg  [`OTPC_ADDR_W-1:0] address_lines_o,
   output reg  [`OTPC_DATA_W-1:0] byte_lines_o,
   output reg                     byte_lines_oe_o,
   input  wire [`OTPC_DATA_W-1:0] byte_lines_i,
   output reg                     unit_select_n_o,
   output reg                     output_drive_n_o,
   output reg                     program_strobe_n_o,
   output reg                     id_voltage_en_o,
   output reg  [1:0]              core_supply_o,
   output reg  [1:0]              program_supply_o
);

   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam ST_IDLE    = 4'h0;
   localparam ST_RAISE   = 4'h1;
   localparam ST_FETCH   = 4'h2;
   localparam ST_SETUP   = 4'h3;
   localparam ST_PULSE   = 4'h4;
   localparam ST_HOLD    = 4'h5;
   localparam ST_VREAD   = 4'h6;
   localparam ST_LOWER   = 4'h7;
   localparam ST_DROP    = 4'h8;
   localparam ST_FINISH  = 4'h9;
   localparam ST_RDWAIT  = 4'hA;
   localparam ST_RDDONE  = 4'hB;

   // Phase of the programming run
   localparam PH_FIRST   = 2'h0;
   localparam PH_VERIFY  = 2'h1;
   localparam PH_FINAL   = 2'h2;

   reg  [3:0]              state;
   reg  [1:0]              phase;
   reg  [3:0]              retries;
   reg  [`OTPC_DATA_W-1:0] want;
   reg                     any_fail;
   reg                     tmr_load;
   reg  [`OTPC_TMR_W-1:0]  tmr_count;
   wire                    tmr_done;

   // Cycle counts as timer-width constants
   function [`OTPC_TMR_W-1:0] cyc;
      input integer n;
      begin
         cyc = n[`OTPC_TMR_W-1:0];
      end
   endfunction

   otpc_timer u_timer
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .load_i  (tmr_load),
      .count_i (tmr_count),
      .done_o  (tmr_done)
   );

   assign busy_o = (state != ST_IDLE);

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Address and data change only while the strobe is high.
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state              <= ST_IDLE;
         phase              <= PH_FIRST;
         retries            <= 4'h0;
         want               <= 8'h00;
         any_fail           <= 1'b0;
         tmr_load           <= 1'b0;
         tmr_count          <= {`OTPC_TMR_W{1'b0}};
         data_req_o         <= 1'b0;
         data_addr_o        <= 17'h00000;
         read_data_o        <= 8'h00;
         read_done_o        <= 1'b0;
         prog_done_o        <= 1'b0;
         prog_pass_o        <= 1'b0;
         fail_addr_o        <= 17'h00000;
         address_lines_o    <= 17'h00000;
         byte_lines_o       <= 8'h00;
         byte_lines_oe_o    <= 1'b0;
         unit_select_n_o    <= 1'b1;        // Standby until needed
         output_drive_n_o   <= 1'b1;
         program_strobe_n_o <= 1'b1;
         id_voltage_en_o    <= 1'b0;
         core_supply_o      <= `OTPC_SUP_NORM;
         program_supply_o   <= `OTPC_SUP_NORM;
      end
      else if (ce_i)
      begin
         tmr_load    <= 1'b0;
         read_done_o <= 1'b0;
         prog_done_o <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (prog_start_i)
               begin
                  // Core supply first, program supply after the setup wait
                  core_supply_o   <= `OTPC_SUP_PROG;
                  address_lines_o <= 17'h00000;
                  data_addr_o     <= 17'h00000;
                  phase           <= PH_FIRST;
                  any_fail        <= 1'b0;
                  tmr_load        <= 1'b1;
                  tmr_count       <= cyc(`OTPC_SETUP_CYC);
                  state           <= ST_RAISE;
               end
               else if (read_start_i || read_id_i)
               begin
                  // Plain read, or identification with only the select bit used
                  address_lines_o  <= read_id_i ?
                                      {16'h0000, read_addr_i[`OTPC_ID_SEL_BIT]} :
                                      read_addr_i;
                  id_voltage_en_o  <= read_id_i;
                  byte_lines_oe_o  <= 1'b0;
                  unit_select_n_o  <= 1'b0;
                  output_drive_n_o <= 1'b0;
                  tmr_load         <= 1'b1;
                  tmr_count        <= cyc(`OTPC_SETUP_CYC);
                  state            <= ST_RDWAIT;
               end
            end
            ST_RAISE:
               if (tmr_done)
               begin
                  program_supply_o <= `OTPC_SUP_PROG;
                  data_req_o       <= 1'b1;
                  state            <= ST_FETCH;
               end
            ST_FETCH:
               // Wait for the intended byte of the current address
               if (data_valid_i)
               begin
                  data_req_o <= 1'b0;
                  want       <= data_i;
                  retries    <= 4'h0;
                  if (phase == PH_FIRST)
                  begin
                     byte_lines_o     <= data_i;
                     byte_lines_oe_o  <= 1'b1;
                     unit_select_n_o  <= 1'b0;
                     output_drive_n_o <= 1'b1;
                     tmr_load         <= 1'b1;
                     tmr_count        <= cyc(`OTPC_SETUP_CYC);
                     state            <= ST_SETUP;
                  end
                  else
                  begin
                     // Verify read of the byte before any retry pulse
                     byte_lines_oe_o  <= 1'b0;
                     unit_select_n_o  <= 1'b0;
                     output_drive_n_o <= 1'b0;
                     tmr_load         <= 1'b1;
                     tmr_count        <= cyc(`OTPC_SETUP_CYC);
                     state            <= ST_VREAD;
                  end
               end
            ST_SETUP:
               if (tmr_done)
               begin
                  program_strobe_n_o <= 1'b0;
                  tmr_load           <= 1'b1;
                  tmr_count          <= cyc(`OTPC_PULSE_CYC);
                  state              <= ST_PULSE;
               end
            ST_PULSE:
               if (tmr_done)
               begin
                  program_strobe_n_o <= 1'b1;
                  tmr_load           <= 1'b1;
                  tmr_count          <= cyc(`OTPC_SETUP_CYC);       // Data hold
                  state              <= ST_HOLD;
               end
            ST_HOLD:
               if (tmr_done)
               begin
                  byte_lines_oe_o <= 1'b0;
                  if (phase == PH_FIRST)
                  begin
                     unit_select_n_o <= 1'b1;
                     if (address_lines_o == `OTPC_LAST_ADDR)
                     begin
                        phase           <= PH_VERIFY;
                        address_lines_o <= 17'h00000;
                        data_addr_o     <= 17'h00000;
                     end
                     else
                     begin
                        address_lines_o <= address_lines_o + 1'b1;
                        data_addr_o     <= address_lines_o + 1'b1;
                     end
                     data_req_o <= 1'b1;
                     state      <= ST_FETCH;
                  end
                  else
                  begin
                     // Verify after each retry pulse
                     output_drive_n_o <= 1'b0;
                     tmr_load         <= 1'b1;
                     tmr_count        <= cyc(`OTPC_SETUP_CYC);
                     state            <= ST_VREAD;
                  end
               end
            ST_VREAD:
               if (tmr_done)
               begin
                  output_drive_n_o <= 1'b1;
                  if (byte_lines_i == want)
                  begin
                     unit_select_n_o <= 1'b1;
                     if (address_lines_o == `OTPC_LAST_ADDR)
                     begin
                        if (phase == PH_VERIFY)
                        begin
                           program_supply_o <= `OTPC_SUP_NORM;
                           tmr_load         <= 1'b1;
                           tmr_count        <= cyc(`OTPC_SETUP_CYC);
                           state            <= ST_LOWER;
                        end
                        else
                           state <= ST_FINISH;
                     end
                     else
                     begin
                        address_lines_o <= address_lines_o + 1'b1;
                        data_addr_o     <= address_lines_o + 1'b1;
                        data_req_o      <= 1'b1;
                        state           <= ST_FETCH;
                     end
                  end
                  else if (phase == PH_FINAL || retries == `OTPC_RETRY_MAX)
                  begin
                     // Part failed: record address and wind down supplies
                     any_fail        <= 1'b1;
                     fail_addr_o     <= address_lines_o;
                     unit_select_n_o <= 1'b1;
                     if (phase == PH_FINAL)
                        state <= ST_FINISH;
                     else
                     begin
                        program_supply_o <= `OTPC_SUP_NORM;
                        tmr_load         <= 1'b1;
                        tmr_count        <= cyc(`OTPC_SETUP_CYC);
                        state            <= ST_DROP;
                     end
                  end
                  else
                  begin
                     retries         <= retries + 1'b1;
                     byte_lines_o    <= want;
                     byte_lines_oe_o <= 1'b1;
                     tmr_load        <= 1'b1;
                     tmr_count       <= cyc(`OTPC_SETUP_CYC);
                     state           <= ST_SETUP;
                  end
               end
            ST_LOWER:
               if (tmr_done)
               begin
                  core_supply_o   <= `OTPC_SUP_NORM;
                  phase           <= PH_FINAL;
                  address_lines_o <= 17'h00000;
                  data_addr_o     <= 17'h00000;
                  data_req_o      <= 1'b1;
                  state           <= ST_FETCH;
               end
            ST_DROP:
               if (tmr_done)
               begin
                  core_supply_o <= `OTPC_SUP_NORM;
                  state         <= ST_FINISH;
               end
            ST_FINISH:
            begin
               prog_done_o <= 1'b1;
               prog_pass_o <= !any_fail;
               state       <= ST_IDLE;
            end
            ST_RDWAIT:
               if (tmr_done)
               begin
                  read_data_o <= byte_lines_i;
                  state       <= ST_RDDONE;
               end
            ST_RDDONE:
            begin
               // Back to standby, data lines float
               unit_select_n_o  <= 1'b1;
               output_drive_n_o <= 1'b1;
               id_voltage_en_o  <= 1'b0;
               read_done_o      <= 1'b1;
               state            <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

endmodule // otpc_programmer

/* File: verif/otpc_checker.sv */
/*
 Concurrent checks on the pin side of the memory programmer.
 Assumes one clock, asynchronous active-high reset, bound to otpc_programmer.
*/
`timescale 1ns/100ps
`include "otpc_regs.vh"

module otpc_checker
(
   // Clock and reset
   input  wire                    clk_i,
   input  wire                    rst_i,
   // Results
   input  wire                    read_done_o,
   input  wire                    prog_done_o,
   input  wire                    data_req_o,
   // Device pins
   input  wire [`OTPC_ADDR_W-1:0] address_lines_o,
   input  wire [`OTPC_DATA_W-1:0] byte_lines_o,
   input  wire                    byte_lines_oe_o,
   input  wire                    unit_select_n_o,
   input  wire                    output_drive_n_o,
   input  wire                    program_strobe_n_o,
   input  wire                    id_voltage_en_o,
   input  wire [1:0]              core_supply_o,
   input  wire [1:0]              program_supply_o
);
   reg [14:0] low_cnt;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Strobe low time in wall-clock cycles, also counted with the enable low
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         low_cnt <= 15'h0000;
      else if (!program_strobe_n_o)
         low_cnt <= low_cnt + 15'h0001;
      else
         low_cnt <= 15'h0000;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   chk_read_mode_held: assert property (read_done_o |->
      !$past(unit_select_n_o) && !$past(output_drive_n_o))
      else $error("read done without read mode");
   chk_no_contention: assert property (byte_lines_oe_o |-> output_drive_n_o)
      else $error("data driven into enabled part");
   chk_prog_mode: assert property (!program_strobe_n_o |-> !unit_select_n_o &&
      output_drive_n_o && byte_lines_oe_o && program_supply_o == `OTPC_SUP_PROG)
      else $error("strobe low outside program mode");
   chk_verify_mode: assert property (!output_drive_n_o |-> program_strobe_n_o)
      else $error("strobe low while reading");
   chk_id_lines: assert property (id_voltage_en_o |-> address_lines_o[16:10] == 7'h00 &&
      address_lines_o[8:1] == 8'h00 && !unit_select_n_o && !output_drive_n_o)
      else $error("bad identification pins");
   chk_pulse_width: assert property ($rose(program_strobe_n_o) |->
      low_cnt >= 15'h2E63 && low_cnt <= 15'h3345)
      else $error("strobe pulse outside 95 to 105 us");
   chk_supply_order: assert property (program_supply_o <= core_supply_o)
      else $error("program supply above core supply");
   chk_core_first: assert property ($rose(program_supply_o == `OTPC_SUP_PROG) |->
      $past(core_supply_o, 2) == `OTPC_SUP_PROG)
      else $error("program supply raised before core");
   chk_pulse_stable: assert property (!program_strobe_n_o [*2] |->
      $stable(address_lines_o) && $stable(byte_lines_o))
      else $error("address or data moved in pulse");
   chk_supply_lower: assert property ($fell(core_supply_o == `OTPC_SUP_PROG) |->
      core_supply_o == `OTPC_SUP_NORM && program_supply_o == `OTPC_SUP_NORM)
      else $error("supplies not lowered to normal");
   chk_done_single: assert property (prog_done_o |=> !prog_done_o)
      else $error("program done longer than one cycle");

   // ---------------------------------------------------------------
   // Coverage of the main scenarios
   // ---------------------------------------------------------------
   cov_read: cover property (read_done_o && !id_voltage_en_o);
   cov_ident: cover property (id_voltage_en_o && address_lines_o[0]);
   cov_pulse: cover property ($rose(program_strobe_n_o));
   cov_data_req: cover property ($fell(data_req_o));
endmodule // otpc_checker

bind otpc_programmer otpc_checker otpc_checker_inst (.*);

/* File: verif/otpc_dev_model.sv */
/*
 Behavioural model of the byte-wide one-time-programmable part.
 Assumes pin levels only; no clock. Erased cells read as all ones.
*/
`timescale 1ns/100ps
`include "otpc_regs.vh"

module otpc_dev_model
#(
   parameter [7:0] MAKER_CODE = 8'hA5,   // Arbitrary value
   parameter [7:0] PART_CODE  = 8'h3C    // Arbitrary value
)
(
   // Pins from the programmer
   input  wire [16:0] address_lines_i,
   input  wire [7:0]  ctl_byte_i,
   input  wire        ctl_oe_i,
   input  wire        unit_select_n_i,
   input  wire        output_drive_n_i,
   input  wire        program_strobe_n_i,
   input  wire        id_voltage_en_i,
   input  wire [1:0]  core_supply_i,
   input  wire [1:0]  program_supply_i,
   // Resolved data lines
   output wire [7:0]  byte_lines_o
);
   reg  [7:0] mem [0:131071];
   reg  [7:0] last;
   wire       dev_drive;
   wire [7:0] dout;
   integer    i;

   // Output only with select and drive low; otherwise floating
   assign dev_drive = !unit_select_n_i && !output_drive_n_i;
   assign dout = id_voltage_en_i ? (address_lines_i[0] ? PART_CODE : MAKER_CODE)
                                 : mem[address_lines_i];
   // No pull on the lines, so a floating bus shows the inverse of its last level
   assign byte_lines_o = dev_drive ? dout : (ctl_oe_i ? ctl_byte_i : ~last);

   always @*
   begin
      if (dev_drive)
         last = dout;
      else if (ctl_oe_i)
         last = ctl_byte_i;
   end

   // A pulse can only clear bits, and only in full program conditions
   always @(posedge program_strobe_n_i)
   begin
      if (!unit_select_n_i && output_drive_n_i && program_supply_i == `OTPC_SUP_PROG
          && core_supply_i == `OTPC_SUP_PROG)
         mem[address_lines_i] = mem[address_lines_i] & ctl_byte_i;
   end

   initial
   begin
      last = 8'h00;
      for (i = 0; i < 131072; i = i + 1)
         mem[i] = 8'hFF;
   end
endmodule // otpc_dev_model

/* File: verif/tb_otpc_programmer.sv */
/*
 Self-checking bench for otpc_programmer with a model of the part.
 Assumes 125 MHz clock; a full array run is too long, so one is aborted.
*/
`timescale 1ns/100ps
`include "otpc_regs.vh"

module tb_otpc_programmer;
   localparam [7:0] MAKER = 8'hA5;   // Arbitrary value
   localparam [7:0] PART  = 8'h3C;   // Arbitrary value
   typedef struct { logic id; logic [16:0] addr; logic [7:0] exp; } otpc_row_t;

   logic        clk_i, rst_i, ce_i, prog_start_i, read_start_i, read_id_i, data_valid_i;
   logic [16:0] read_addr_i;
   logic [7:0]  data_i;
   wire         busy_o, data_req_o, read_done_o, prog_done_o, prog_pass_o, byte_lines_oe_o;
   wire         unit_select_n_o, output_drive_n_o, program_strobe_n_o, id_voltage_en_o;
   wire  [16:0] data_addr_o, fail_addr_o, address_lines_o;
   wire  [7:0]  read_data_o, byte_lines_o, byte_lines;
   wire  [1:0]  core_supply_o, program_supply_o;
   int          errors, cmp_count, cyc, t0, i;
   logic        saw_read;
   otpc_row_t   rows [0:6] = '{'{1'h0, 17'h00005, 8'h96}, '{1'h0, 17'h1FFFF, 8'h81},
      '{1'h0, 17'h00200, 8'h5A}, '{1'h0, 17'h00006, 8'hFF}, '{1'h1, 17'h00000, MAKER},
      '{1'h1, 17'h00001, PART}, '{1'h1, 17'h1FFFE, MAKER}};

   otpc_programmer otpc_programmer_inst (.byte_lines_i(byte_lines), .*);

   otpc_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dev_inst (
      .address_lines_i(address_lines_o), .ctl_byte_i(byte_lines_o),
      .ctl_oe_i(byte_lines_oe_o), .unit_select_n_i(unit_select_n_o),
      .output_drive_n_i(output_drive_n_o), .program_strobe_n_i(program_strobe_n_o),
      .id_voltage_en_i(id_voltage_en_o), .core_supply_i(core_supply_o),
      .program_supply_i(program_supply_o), .byte_lines_o(byte_lines));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] pat(input logic [16:0] a);
      pat = a[7:0] ^ 8'hC3;
   endfunction

   function automatic logic hit(input int sel);
      case (sel)
         0: hit = (read_done_o === 1'b1);
         1: hit = (data_req_o === 1'b1);
         2: hit = (program_strobe_n_o === 1'b0);
         default: hit = (program_strobe_n_o === 1'b1);
      endcase
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // Bounded wait, sampling 2 ns after each edge
   task automatic wait_for(input int sel, input int lim);
      int n = 0;
      while (!hit(sel) && n < lim)
      begin
         @(posedge clk_i);
         #2;
         n++;
      end
      if (n >= lim)
      begin
         errors++;
         $display("mismatch at %0t: wait ran out", $time);
      end
   endtask

   task automatic rd(input logic id, input logic [16:0] addr);
      @(posedge clk_i);
      #1;
      read_start_i = !id;
      read_id_i = id;
      read_addr_i = addr;
      @(posedge clk_i);
      #1;
      t0 = cyc;
      read_start_i = 1'b0;
      read_id_i = 1'b0;
   endtask

   task automatic pins_idle;
      check({unit_select_n_o, output_drive_n_o, program_strobe_n_o, byte_lines_oe_o, busy_o},
            5'h1C);
      check({core_supply_o, program_supply_o}, {`OTPC_SUP_NORM, `OTPC_SUP_NORM});
      check({prog_pass_o, fail_addr_o}, 18'h00000);
   endtask

   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock, timeout and data source
   // ---------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Cycle count doubles as the hang limit
   always @(posedge clk_i)
   begin
      cyc++;
      if (output_drive_n_o === 1'b0)
         saw_read = 1'b1;
      if (cyc == 40000)
      begin
         errors++;
         $display("mismatch at %0t: run too long", $time);
         conclude;
      end
   end

   // Fast source: valid follows the request 1 ns after the edge that raises it
   always @(posedge clk_i)
   begin
      #1;
      data_valid_i = data_req_o;
      data_i = pat(data_addr_o);
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {rst_i, ce_i} = 2'h3;
      {prog_start_i, read_start_i, read_id_i, data_valid_i, saw_read} = 5'h00;
      read_addr_i = 17'h00000;
      data_i = 8'h00;
      repeat (3) @(posedge clk_i);
      #1;
      pins_idle;
      rst_i = 1'b0;
      for (i = 0; i < 3; i++)
         dev_inst.mem[rows[i].addr] = rows[i].exp;
      // 250-cycle wait plus 3 of latency
      for (i = 0; i < 7; i++)
      begin
         rd(rows[i].id, rows[i].addr);
         wait_for(0, 400);
         check(read_data_o, rows[i].exp);
         check(cyc - t0, 253);
      end
      // A command during a read is dropped
      rd(1'b0, 17'h00005);
      repeat (20) @(posedge clk_i);
      #1 {read_start_i, read_addr_i} = {1'b1, 17'h1FFFF};
      @(posedge clk_i);
      #1 read_start_i = 1'b0;
      wait_for(0, 400);
      check(read_data_o, 8'h96);
      check(cyc - t0, 253);
      // Clock enable low freezes the access wait
      rd(1'b0, 17'h00200);
      repeat (40) @(posedge clk_i);
      #1 ce_i = 1'b0;
      repeat (100) @(posedge clk_i);
      #1 ce_i = 1'b1;
      wait_for(0, 400);
      check(read_data_o, 8'h5A);
      check(cyc - t0, 353);
      // First two pulses of the first pass, then abort
      @(posedge clk_i);
      #1 prog_start_i = 1'b1;
      @(posedge clk_i);
      #1 prog_start_i = 1'b0;
      wait_for(1, 1000);
      check(data_addr_o, 17'h00000);
      wait_for(2, 1000);
      t0 = cyc;
      check({core_supply_o, program_supply_o}, {`OTPC_SUP_PROG, `OTPC_SUP_PROG});
      check({address_lines_o, byte_lines_o}, {17'h00000, pat(17'h00000)});
      wait_for(3, 13000);
      check(cyc - t0, 12502);
      saw_read = 1'b0;
      wait_for(2, 2000);
      check(saw_read, 1'b0);
      check(address_lines_o, 17'h00001);
      check(byte_lines_o, pat(17'h00001));
      check(dev_inst.mem[0], pat(17'h00000));
      repeat (100) @(posedge clk_i);
      #1 rst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      pins_idle;
      rst_i = 1'b0;
      rd(1'b0, 17'h00000);
      wait_for(0, 400);
      check(read_data_o, pat(17'h00000));
      conclude;
   end
endmodule // tb_otpc_programmer
